// File: core/wdcm_top.sv
`timescale 1ns/100ps
`default_nettype none
module wdcm_top #(
	parameter logic [15:0] CM_LIMIT = 16'(wdcm_pkg::CM_LIMIT_CYC)
) (
	input  wire logic       core_clk,
	input  wire logic       reset_n,
	input  wire logic       por_n,
	input  wire logic       option_wd_dis,
	input  wire logic       svc_wr_en,
	input  wire logic [7:0] svc_wr_data,
	output var  logic [7:0] svc_rd_data,
	input  wire logic       halt_mode,
	input  wire logic       idle_mode,
	input  wire logic       isp_enter,
	input  wire logic       isp_exit,
	input  wire logic       inst_clk_pin,
	input  wire logic       fault_pin_in,
	output var  logic       fault_pin_out,
	output var  logic       fault_pin_oe,
	input  wire logic [2:0] idle_sel,
	input  wire logic       idle_pend_clr,
	output var  logic       idle_tick_pending
);
	// ********************************
	// Pin synchronisers
	// ********************************
	logic ic_s1_q;
	logic ic_s2_q;
	logic ic_s3_q;
	logic pin_s1_q;
	logic pin_s2_q;

	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			ic_s1_q  <= 1'b0;
			ic_s2_q  <= 1'b0;
			ic_s3_q  <= 1'b0;
			pin_s1_q <= 1'b1;
			pin_s2_q <= 1'b1;
		end else begin
			ic_s1_q  <= inst_clk_pin;
			ic_s2_q  <= ic_s1_q;
			ic_s3_q  <= ic_s2_q;
			pin_s1_q <= fault_pin_in;
			pin_s2_q <= pin_s1_q;
		end
	end

	// ********************************
	// Timebase and submodules
	// ********************************
	wdcm_tick_if tb ();

	assign tb.tick = ic_s2_q && !ic_s3_q;

	wdcm_clkmon #(
		.LIMIT (CM_LIMIT)
	) u_clkmon (
		.core_clk (core_clk),
		.reset_n  (reset_n),
		.tb       (tb.mon)
	);

	wdcm_idle_timer u_idle (
		.core_clk          (core_clk),
		.por_n             (por_n),
		.reset_n           (reset_n),
		.tb                (tb.tmr),
		.idle_sel          (idle_sel),
		.idle_pend_clr     (idle_pend_clr),
		.idle_tick_pending (idle_tick_pending)
	);

	// ********************************
	// Mode edges
	// ********************************
	logic halt_q;
	logic idle_q;
	logic isp_q;
	logic halt_exit;
	logic idle_exit;
	logic freeze;

	// Halt and idle come from the core on this clock, so they need no synchroniser.
	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			halt_q <= 1'b0;
			idle_q <= 1'b0;
		end else begin
			halt_q <= halt_mode;
			idle_q <= idle_mode;
		end
	end

	assign halt_exit = halt_q && !halt_mode;
	assign idle_exit = idle_q && !idle_mode;
	assign freeze    = halt_mode || idle_mode;

	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			isp_q <= 1'b0;
		end else if (isp_enter) begin
			isp_q <= 1'b1;
		end else if (isp_exit) begin
			isp_q <= 1'b0;
		end
	end

	// ********************************
	// Service decode
	// ********************************
	wdcm_pkg::wdcm_state_t state_q;
	logic [16:0] wcnt_q;
	logic [16:0] upper;
	logic [1:0]  sel_q;
	logic        cm_en_q;
	logic        cfg_done_q;
	logic [4:0]  hold_q;
	logic        wd_on;
	logic        svc;
	logic        key_ok;
	logic        full_ok;
	logic        early;
	logic        svc_good;
	logic        svc_bad;
	logic        hw_svc;
	logic        timeout;

	assign wd_on    = !option_wd_dis;
	assign upper    = wdcm_pkg::UPPER_BASE << sel_q;
	assign svc      = svc_wr_en && (state_q == wdcm_pkg::ST_RUN);
	assign key_ok   = svc_wr_data[wdcm_pkg::KEY_HI:wdcm_pkg::KEY_LO] == wdcm_pkg::SVC_KEY;
	assign full_ok  = key_ok && (svc_wr_data[wdcm_pkg::SEL_HI:wdcm_pkg::SEL_LO] == sel_q)
	                  && (svc_wr_data[wdcm_pkg::CM_BIT] == cm_en_q);
	// early service, first service exempt, suppressed in boot ROM
	assign early    = cfg_done_q && !isp_q && (wcnt_q < wdcm_pkg::LOWER_LIM);
	assign svc_good = svc && (cfg_done_q ? (full_ok && !early) : key_ok);
	assign svc_bad  = svc && !svc_good;
	// halt reload, idle service, boot-ROM services
	assign hw_svc   = halt_exit || idle_exit || isp_enter || isp_exit;
	assign timeout  = tb.tick && !freeze && (wcnt_q == upper - wdcm_pkg::WCNT_ONE);

	// ********************************
	// Configuration
	// ********************************
	// reset defaults, first write with the right key locks
	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			sel_q      <= wdcm_pkg::SEL_RST;
			cm_en_q    <= wdcm_pkg::CM_EN_RST;
			cfg_done_q <= 1'b0;
		end else if (svc && !cfg_done_q && key_ok) begin
			sel_q      <= svc_wr_data[wdcm_pkg::SEL_HI:wdcm_pkg::SEL_LO];
			cm_en_q    <= svc_wr_data[wdcm_pkg::CM_BIT];
			cfg_done_q <= 1'b1;
		end
	end

	assign tb.cm_en = cm_en_q;

	// ********************************
	// Fault sequence
	// ********************************
	// drive, sense, hold, release
	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			state_q <= wdcm_pkg::ST_RUN;
			hold_q  <= 5'h00;
		end else if (!wd_on) begin
			state_q <= wdcm_pkg::ST_RUN;
			hold_q  <= 5'h00;
		end else begin
			case (state_q)
				wdcm_pkg::ST_RUN: begin
					if (svc_bad || timeout) begin
						state_q <= wdcm_pkg::ST_DRIVE;
					end
				end
				// A pin held high from outside keeps the drive on, since the hold only starts once low is sensed.
				wdcm_pkg::ST_DRIVE: begin
					hold_q <= 5'h00;
					if (!pin_s2_q) begin
						state_q <= wdcm_pkg::ST_HOLD;
					end
				end
				wdcm_pkg::ST_HOLD: begin
					hold_q <= hold_q + 5'h01;
					if (hold_q == wdcm_pkg::FAULT_HOLD - 5'h01) begin
						state_q <= wdcm_pkg::ST_REL;
					end
				end
				wdcm_pkg::ST_REL: begin
					if (pin_s2_q) begin
						state_q <= wdcm_pkg::ST_RUN;
					end
				end
				default: begin
					state_q <= wdcm_pkg::ST_RUN;
				end
			endcase
		end
	end

	// ********************************
	// Window counter
	// ********************************
	// The counter holds its value through a fault so the error cause stays visible.
	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			wcnt_q <= 17'h00000;
		end else if (!wd_on) begin
			wcnt_q <= 17'h00000;
		end else if (state_q == wdcm_pkg::ST_REL) begin
			if (pin_s2_q) begin
				wcnt_q <= 17'h00000;
			end
		end else if (state_q == wdcm_pkg::ST_RUN) begin
			if (svc_good || hw_svc) begin
				wcnt_q <= 17'h00000;
			end else if (tb.tick && !freeze && !timeout) begin
				wcnt_q <= wcnt_q + wdcm_pkg::WCNT_ONE;
			end
		end
	end

	// ********************************
	// Outputs
	// ********************************
	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			fault_pin_oe  <= 1'b0;
			fault_pin_out <= 1'b0;
			svc_rd_data   <= 8'h00;
		end else begin
			fault_pin_oe  <= wd_on && ((state_q == wdcm_pkg::ST_DRIVE) ||
			                 (state_q == wdcm_pkg::ST_HOLD) || tb.cm_err);
			fault_pin_out <= 1'b0;
			svc_rd_data   <= {sel_q, wdcm_pkg::KEY_READ, cm_en_q};
		end
	end

	// ********************************
	// Checks
	// ********************************
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!reset_n);

	chk_key_reads_zero: assert property (
		svc_rd_data[wdcm_pkg::KEY_HI:wdcm_pkg::KEY_LO] == 5'h00) else $error("key visible");
	chk_cfg_locked: assert property (
		cfg_done_q |=> $stable(sel_q) && $stable(cm_en_q)) else $error("config changed");
	chk_upper_timeout: assert property (
		(wd_on && state_q == wdcm_pkg::ST_RUN && timeout) |=> state_q == wdcm_pkg::ST_DRIVE)
		else $error("timeout missed");
	chk_early_service: assert property (
		(wd_on && svc && cfg_done_q && !isp_q && wcnt_q < wdcm_pkg::LOWER_LIM)
		|=> state_q == wdcm_pkg::ST_DRIVE) else $error("early service accepted");
	chk_mismatch_err: assert property (
		(wd_on && svc && cfg_done_q && !full_ok) |=> state_q == wdcm_pkg::ST_DRIVE)
		else $error("mismatch accepted");
	chk_fault_drive: assert property (
		(wd_on && state_q == wdcm_pkg::ST_HOLD) |=> fault_pin_oe) else $error("pin not driven");
	chk_hold_length: assert property (
		(wd_on && state_q == wdcm_pkg::ST_DRIVE && !pin_s2_q) |=> (state_q == wdcm_pkg::ST_HOLD) [*8])
		else $error("hold too short");
	chk_write_ignored: assert property (
		(wd_on && state_q != wdcm_pkg::ST_RUN && state_q != wdcm_pkg::ST_REL) |=> $stable(wcnt_q))
		else $error("counter moved in fault");
	chk_option_off: assert property (
		option_wd_dis |=> !fault_pin_oe) else $error("pin driven while disabled");
	chk_frozen: assert property (
		(freeze && state_q == wdcm_pkg::ST_RUN && !hw_svc && !svc) |=> $stable(wcnt_q))
		else $error("counter ran while frozen");
	chk_restart_zero: assert property (
		(wd_on && state_q == wdcm_pkg::ST_REL && pin_s2_q)
		|=> (state_q == wdcm_pkg::ST_RUN && wcnt_q == 17'h00000)) else $error("window not restarted");
	chk_cm_drive: assert property (
		(wd_on && tb.cm_err) |=> fault_pin_oe) else $error("monitor error not driven");
	chk_idle_service: assert property (
		(wd_on && state_q == wdcm_pkg::ST_RUN && idle_exit) |=> wcnt_q == 17'h00000)
		else $error("idle exit did not service");
	chk_first_free: assert property (
		(wd_on && svc && !cfg_done_q && key_ok && !timeout)
		|=> (state_q == wdcm_pkg::ST_RUN && cfg_done_q)) else $error("first service refused");

	cov_first_service: cover property (svc && !cfg_done_q && key_ok);
	cov_timeout: cover property (state_q == wdcm_pkg::ST_RUN ##1 state_q == wdcm_pkg::ST_DRIVE);
	cov_cm_fault: cover property (tb.cm_err && fault_pin_oe);
	cov_restart: cover property (state_q == wdcm_pkg::ST_REL ##1 state_q == wdcm_pkg::ST_RUN);
endmodule // wdcm_top
`default_nettype wire

// File: core/wdcm_pkg.sv
package wdcm_pkg;
	localparam int          WCNT_W        = 17;
	localparam int          SEL_HI        = 7;
	localparam int          SEL_LO        = 6;
	localparam int          KEY_HI        = 5;
	localparam int          KEY_LO        = 1;
	localparam int          CM_BIT        = 0;
	localparam logic [4:0]  SVC_KEY       = 5'h0C;
	localparam logic [4:0]  KEY_READ      = 5'h00;
	localparam logic [1:0]  SEL_RST       = 2'h3;
	localparam logic        CM_EN_RST     = 1'b1;
	localparam logic [16:0] LOWER_LIM     = 17'h00800;
	localparam logic [16:0] UPPER_BASE    = 17'h02000;
	localparam logic [16:0] WCNT_ONE      = 17'h00001;
	localparam logic [4:0]  FAULT_HOLD    = 5'h18;
	localparam logic [4:0]  CM_REL_TICKS  = 5'h10;
	localparam int          CLK_FREQ_HZ   = 40_000_000;
	localparam int          CM_LIMIT_US   = 1000;
	localparam int          CM_LIMIT_CYC  = CLK_FREQ_HZ / 1_000_000 * CM_LIMIT_US;
	localparam int          CM_CNT_W      = 16;
	localparam int          IT_W          = 17;
	localparam logic [24:0] IT_BITS       = {5'h10, 5'h05, 5'h04, 5'h03, 5'h02};

	typedef enum logic [3:0] {
		ST_RUN   = 4'h1,
		ST_DRIVE = 4'h2,
		ST_HOLD  = 4'h4,
		ST_REL   = 4'h8
	} wdcm_state_t;
endpackage

// File: core/wdcm_tick_if.sv
`timescale 1ns/100ps
`default_nettype none
interface wdcm_tick_if;
	logic tick;
	logic cm_en;
	logic cm_err;
	modport top (output tick, output cm_en, input cm_err);
	modport mon (input tick, input cm_en, output cm_err);
	modport tmr (input tick);
endinterface // wdcm_tick_if
`default_nettype wire

// File: core/wdcm_clkmon.sv
`timescale 1ns/100ps
`default_nettype none
module wdcm_clkmon #(
	parameter logic [15:0] LIMIT = 16'(wdcm_pkg::CM_LIMIT_CYC)
) (
	input  wire logic   core_clk,
	input  wire logic   reset_n,
	wdcm_tick_if.mon    tb
);
	logic [15:0] gap_q;
	logic [4:0]  rel_q;
	logic        err_q;

	assign tb.cm_err = err_q;

	// The gap limit sits between the 5 kHz and 10 Hz tick periods.
	// tick gap count
	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			gap_q <= 16'h0000;
		end else if (tb.tick) begin
			gap_q <= 16'h0000;
		end else if (gap_q != LIMIT) begin
			gap_q <= gap_q + 16'h0001;
		end
	end

	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			err_q <= 1'b0;
			rel_q <= 5'h00;
		end else if (!tb.cm_en) begin
			err_q <= 1'b0;
			rel_q <= 5'h00;
		end else if (gap_q == LIMIT) begin
			err_q <= 1'b1;
			rel_q <= 5'h00;
		end else if (err_q && tb.tick) begin
			if (rel_q == wdcm_pkg::CM_REL_TICKS - 5'h01) begin
				err_q <= 1'b0;
				rel_q <= 5'h00;
			end else begin
				rel_q <= rel_q + 5'h01;
			end
		end
	end

	chk_cm_disabled_quiet: assert property (@(posedge core_clk) disable iff (!reset_n)
		!tb.cm_en |=> !err_q) else $error("clock monitor error while disabled");
	chk_cm_slow_trip: assert property (@(posedge core_clk) disable iff (!reset_n)
		(tb.cm_en && gap_q == LIMIT) |=> err_q) else $error("slow clock not flagged");
endmodule // wdcm_clkmon
`default_nettype wire

// File: core/wdcm_idle_timer.sv
`timescale 1ns/100ps
`default_nettype none
module wdcm_idle_timer (
	input  wire logic       core_clk,
	input  wire logic       por_n,
	input  wire logic       reset_n,
	wdcm_tick_if.tmr        tb,
	input  wire logic [2:0] idle_sel,
	input  wire logic       idle_pend_clr,
	output var  logic       idle_tick_pending
);
	logic [16:0] cnt_q;
	logic [4:0]  bit_idx;
	logic        sel_bit;
	logic        sel_bit_q;

	always_comb begin
		bit_idx = wdcm_pkg::IT_BITS[4:0];
		if (idle_sel < 3'h5) begin
			bit_idx = wdcm_pkg::IT_BITS[5 * idle_sel +: 5];
		end
	end
	assign sel_bit = cnt_q[bit_idx];

	// The counter only sees power-on reset so software can keep sync across resets.
	always_ff @(posedge core_clk or negedge por_n) begin
		if (!por_n) begin
			cnt_q     <= 17'h00000;
			sel_bit_q <= 1'b0;
		end else begin
			sel_bit_q <= sel_bit;
			if (tb.tick) begin
				cnt_q <= cnt_q + 17'h00001;
			end
		end
	end

	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			idle_tick_pending <= 1'b0;
		end else if (sel_bit != sel_bit_q) begin
			idle_tick_pending <= 1'b1;
		end else if (idle_pend_clr) begin
			idle_tick_pending <= 1'b0;
		end
	end

	chk_pend_sticky: assert property (@(posedge core_clk) disable iff (!reset_n)
		(idle_tick_pending && !idle_pend_clr) |=> idle_tick_pending) else $error("pending lost");
endmodule // wdcm_idle_timer
`default_nettype wire

// File: dv/wdcm_reset_model.sv
`timescale 1ns/100ps
`default_nettype none
module wdcm_reset_model (
	input  wire logic fault_pin_out,
	input  wire logic fault_pin_oe,
	output var  logic fault_pin_in,
	output var  int   low_pulses
);
	// ****************************************
	// Shared pin with weak pull-up
	// ****************************************
	// pull-up release
	always_comb begin
		fault_pin_in = fault_pin_oe ? fault_pin_out : 1'b1;
	end

	// The reset circuit only counts how often it was asked to reset the system.
	initial begin
		low_pulses = 0;
		forever begin
			@(negedge fault_pin_in);
			low_pulses = low_pulses + 1;
		end
	end
endmodule // wdcm_reset_model
`default_nettype wire

// File: dv/tb_top.sv
`timescale 1ns/100ps
`default_nettype none
module tb_top;
	typedef struct {
		logic [7:0] data;
		int         wait_t;
		logic       fault;
	} wdcm_row_t;

	logic       core_clk, reset_n, por_n, option_wd_dis, svc_wr_en;
	logic [7:0] svc_wr_data, svc_rd_data;
	logic       halt_mode, idle_mode, isp_enter, isp_exit, inst_clk_pin, inst_run;
	logic       fault_pin_in, fault_pin_out, fault_pin_oe, idle_pend_clr, idle_tick_pending;
	logic [2:0] idle_sel;
	int         mismatches, samples_checked, low_pulses;

	// Small monitor limit keeps the dead-clock scenarios short.
	wdcm_top #(.CM_LIMIT(16'h00C8)) dut (
		.core_clk(core_clk), .reset_n(reset_n), .por_n(por_n), .option_wd_dis(option_wd_dis),
		.svc_wr_en(svc_wr_en), .svc_wr_data(svc_wr_data), .svc_rd_data(svc_rd_data),
		.halt_mode(halt_mode), .idle_mode(idle_mode), .isp_enter(isp_enter), .isp_exit(isp_exit),
		.inst_clk_pin(inst_clk_pin), .fault_pin_in(fault_pin_in), .fault_pin_out(fault_pin_out),
		.fault_pin_oe(fault_pin_oe), .idle_sel(idle_sel), .idle_pend_clr(idle_pend_clr),
		.idle_tick_pending(idle_tick_pending)
	);

	wdcm_reset_model partner (
		.fault_pin_out(fault_pin_out), .fault_pin_oe(fault_pin_oe),
		.fault_pin_in(fault_pin_in), .low_pulses(low_pulses)
	);

	// ****************************************
	// Clocks and watchdog
	// ****************************************
	initial begin
		core_clk = 1'b0;
		forever #12.5 core_clk = ~core_clk;
	end

	// Instruction clock at half the core rate; it stands still when stopped.
	initial begin
		inst_clk_pin = 1'b0;
		forever @(negedge core_clk) if (inst_run) inst_clk_pin <= ~inst_clk_pin;
	end

	// The tests take under 50k cycles; this limit of 80k cycles leaves margin.
	initial begin
		#2_000_000;
		mismatches = mismatches + 1;
		end_of_test();
	end

	// ****************************************
	// Tasks
	// ****************************************
	task automatic end_of_test();
		if (mismatches == 0 && samples_checked > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask

	task automatic chk_byte(input string name, input logic [7:0] exp, input logic [7:0] got);
		samples_checked = samples_checked + 1;
		if (got !== exp) begin
			$display("Error %s expected %h seen %h", name, exp, got);
			mismatches = mismatches + 1;
		end
	endtask

	task automatic chk_bit(input string name, input logic exp, input logic got);
		samples_checked = samples_checked + 1;
		if (got !== exp) begin
			$display("Error %s expected %b seen %b", name, exp, got);
			mismatches = mismatches + 1;
		end
	endtask

	task automatic ticks(input int n);
		repeat (n) @(posedge inst_clk_pin);
		@(negedge core_clk);
	endtask

	task automatic wr(input logic [7:0] d);
		@(negedge core_clk);
		svc_wr_en   = 1'b1;
		svc_wr_data = d;
		@(negedge core_clk);
		svc_wr_en   = 1'b0;
	endtask

	task automatic pulse(ref logic sig);
		@(negedge core_clk);
		sig = 1'b1;
		@(negedge core_clk);
		sig = 1'b0;
	endtask

	// Looks for a fault after a write; if one comes, times the drive and waits for the pin to settle high.
	task automatic settle(input logic exp);
		logic seen;
		int   n;
		seen = 1'b0;
		n    = 0;
		repeat (6) @(negedge core_clk) if (fault_pin_oe === 1'b1) seen = 1'b1;
		chk_bit("fault raised", exp, seen);
		if (seen) begin
			while (fault_pin_oe === 1'b1 && n < 300) begin
				@(negedge core_clk);
				n = n + 1;
			end
			chk_bit("fault hold in range", 1'b1, n >= 16 && n <= 40);
			repeat (4) @(negedge core_clk);
		end
	endtask

	task automatic do_reset();
		@(negedge core_clk);
		reset_n = 1'b0;
		repeat (4) @(negedge core_clk);
		chk_bit("oe in reset", 1'b0, fault_pin_oe);
		chk_byte("read in reset", 8'h00, svc_rd_data);
		reset_n = 1'b1;
		repeat (2) @(negedge core_clk);
		chk_byte("read after reset", 8'hC1, svc_rd_data);
	endtask

	// ****************************************
	// Ordinary services, one row each
	// ****************************************
	wdcm_row_t rows [7] = '{
		'{8'h19, 0,    1'b0},
		'{8'h19, 2060, 1'b0},
		'{8'hD9, 2060, 1'b1},
		'{8'h18, 2060, 1'b1},
		'{8'h1B, 2060, 1'b1},
		'{8'h19, 10,   1'b1},
		'{8'h19, 2060, 1'b0}
	};

	initial begin
		{reset_n, por_n, option_wd_dis, svc_wr_en, halt_mode, idle_mode} = 6'h00;
		{isp_enter, isp_exit, idle_pend_clr, inst_run} = 4'h0;
		svc_wr_data     = 8'h00;
		idle_sel        = 3'h0;
		mismatches      = 0;
		samples_checked = 0;
		repeat (4) @(negedge core_clk);
		por_n = 1'b1;
		do_reset();
		// Instruction clock never started after reset.
		repeat (250) @(negedge core_clk);
		chk_bit("dead clock fault", 1'b1, fault_pin_oe);
		inst_run = 1'b1;
		ticks(40);
		chk_bit("monitor release", 1'b0, fault_pin_oe);
		repeat (4) @(negedge core_clk);
		foreach (rows[i]) begin
			if (rows[i].wait_t > 0)
				ticks(rows[i].wait_t);
			wr(rows[i].data);
			settle(rows[i].fault);
			chk_byte("locked read", 8'h01, svc_rd_data);
		end
		// ****************************************
		// Halt, idle and boot-ROM window handling
		// ****************************************
		ticks(2060);
		halt_mode = 1'b1;
		ticks(50);
		halt_mode = 1'b0;
		ticks(10);
		wr(8'h19);
		settle(1'b1);
		ticks(2060);
		idle_mode = 1'b1;
		ticks(50);
		idle_mode = 1'b0;
		ticks(10);
		wr(8'h19);
		settle(1'b1);
		pulse(isp_enter);
		ticks(10);
		wr(8'h19);
		settle(1'b0);
		pulse(isp_exit);
		ticks(10);
		wr(8'h19);
		settle(1'b1);
		// Upper limit of window 00 is 8192 ticks.
		// Counting starts a tick or two after the restart, so the limit lands inside the settle window.
		ticks(8150);
		chk_bit("no early timeout", 1'b0, fault_pin_oe);
		ticks(40);
		chk_bit("no early timeout", 1'b0, fault_pin_oe);
		settle(1'b1);
		// ****************************************
		// Option disable, mid-run reset, monitor off
		// ****************************************
		option_wd_dis = 1'b1;
		wr(8'hFF);
		settle(1'b0);
		option_wd_dis = 1'b0;
		do_reset();
		wr(8'h18);
		settle(1'b0);
		chk_byte("monitor off read", 8'h00, svc_rd_data);
		inst_run = 1'b0;
		repeat (250) @(negedge core_clk);
		chk_bit("monitor disabled", 1'b0, fault_pin_oe);
		inst_run = 1'b1;
		// ****************************************
		// Idle timer pending flag
		// ****************************************
		for (int s = 0; s < 4; s++) begin
			idle_sel = 3'(s);
			pulse(idle_pend_clr);
			ticks((1 << (s + 2)) + 2);
			chk_bit("pending set", 1'b1, idle_tick_pending);
		end
		idle_sel = 3'h4;
		ticks(2);
		pulse(idle_pend_clr);
		ticks(100);
		chk_bit("slow select quiet", 1'b0, idle_tick_pending);
		// Nine faults were provoked: dead clock, four rows, halt, idle, boot-ROM return and timeout.
		chk_byte("reset requests", 8'h09, 8'(low_pulses));
		end_of_test();
	end
endmodule // tb_top
`default_nettype wire
